// ### hdl/lteccfg_regs.vh
// Register offsets, field positions, reset values and timing constants of the error capture / port-write block
// How it works
// - Capture register freezes on first enabled logical/transport error until cleared.
// - Capture stores format type in field 0:3, transaction type in 4:7, rest zero.
// - Transaction type is always the four bits after the format type.
// - A maintenance packet is expected to carry format type eight; capture goes by errKind and never checks the format type.
// - Capture only for maintenance request, response, port-write with hop count zero.
// - A correctly formatted failing maintenance request leaves capture unchanged.
// - Generated port-writes use the programmed target ID as destination.
// - Generated port-writes go to the port chosen by routing lookup.
// - Wide-ID select clear gives 8-bit destination, set gives 16-bit destination.
// - High target-ID byte is ignored unless wide-ID select is set.
// - Writes update every port copy; reads return port 0 copy.
// - Sixteen-bit lifetime bounds packet residence; zero disables the check.
// - Expiry falls between 78 and 117 register-bus periods times lifetime.
// - Register-bus period is 16 ns, 12.8 ns, or twice reference period.
// - Expired packet is discarded, port drop flag set, port-write may be issued.
// - Capture only for error types whose enable bit is set; enables reset zero.
`ifndef LTECCFG_REGS_VH
`define LTECCFG_REGS_VH
`define LTEC_OFS_CAPTURE 16'h101C
`define LTEC_OFS_PWTARGET 16'h1028
`define LTEC_OFS_LIFETIME 16'h102C
`define LTEC_OFS_ERRENABLE 16'h1030
`define LTEC_OFS_INTSTAT 16'h1034
`define LTEC_OFS_INTMASK 16'h1038
`define LTEC_RESET_VALUE 32'h00000000
// Field positions in little-endian bit numbering (documented bit 0 is bit 31)
`define LTEC_FTYPE_HI 31
`define LTEC_FTYPE_LO 28
`define LTEC_TTYPE_HI 27
`define LTEC_TTYPE_LO 24
`define LTEC_TIDH_HI 31
`define LTEC_TIDH_LO 24
`define LTEC_TIDL_HI 23
`define LTEC_TIDL_LO 16
`define LTEC_WIDE_BIT 15
`define LTEC_TTL_HI 31
`define LTEC_TTL_LO 16
`define LTEC_FTYPE_MAINT 4'h8
// Timing: register-bus period in picoseconds, expiry bounds in periods
`define LTEC_REGBUS_PS 16000
`define LTEC_CLK_PS 20000
`define LTEC_TTL_MIN_PERIODS 78
`define LTEC_TTL_MAX_PERIODS 117
// Ageing tick in clocks; four ticks per lifetime unit keep even a lifetime of one inside the window
`define LTEC_TICK_CYC 16
// Interrupt status bits
`define LTEC_INT_CAPTURE 0
`define LTEC_INT_DROP 1
`endif

// ### hdl/lteccfg_top.v
// Error capture, port-write target and packet lifetime register block with per-slot ageing
`include "lteccfg_regs.vh"
module lteccfg_top #(
    parameter NPORTS = 4,
    parameter ID_W = 16
) (
    // Clock and reset
    input wire clk,
    input wire srst,
    // Register port
    input wire [15:0] regAddr,
    input wire [31:0] regWrData,
    input wire regWrStb,
    input wire regRdStb,
    output reg [31:0] regRdData,
    // Logical-layer error report from fabric (same clock)
    input wire errValid,
    input wire [2:0] errType,
    input wire [1:0] errKind,
    input wire [7:0] errHopCount,
    input wire errWellFormed,
    input wire [3:0] errFtype,
    input wire [3:0] errTtype,
    // Packet ageing per port: packet enters, leaves
    input wire [NPORTS-1:0] pktStart,
    input wire [NPORTS-1:0] pktDone,
    // Port-write generation request
    input wire pwReq,
    input wire [3:0] pwLutPort,
    // Outputs
    output reg [NPORTS-1:0] pktExpire,
    output reg [NPORTS-1:0] outputDrop,
    output reg pwValid,
    output reg [ID_W-1:0] pwDestId,
    output reg pwWide,
    output reg [3:0] pwOutPort,
    output reg irq
);

localparam [1:0] KIND_MREQ = 2'h0;
localparam [1:0] KIND_MRSP = 2'h1;
localparam [1:0] KIND_PW = 2'h2;
localparam integer TICK_CYC = `LTEC_TICK_CYC;

////////////////////////////////////////////////////////////////////////////////
// Register storage, one copy per port for broadcast registers
reg [7:0] captureFf;
reg lockFf;
reg [2:0] errEnableFf;
reg [16:0] pwTargetFf [0:NPORTS-1];
reg [15:0] lifetimeFf [0:NPORTS-1];
reg [1:0] intStatFf;
reg [1:0] intMaskFf;
reg [NPORTS-1:0] dropFf;
integer i;

function [31:0] pwWord;
    input [16:0] v;
    begin
        pwWord = {v[16:9], v[8:1], v[0], 15'h0000};
    end
endfunction

wire isCapture = regAddr == `LTEC_OFS_CAPTURE;
wire isPwTarget = regAddr == `LTEC_OFS_PWTARGET;
wire isLifetime = regAddr == `LTEC_OFS_LIFETIME;

// Capture qualifies only for hop-0 maintenance traffic with enabled error type
wire kindOk = errKind == KIND_MREQ || errKind == KIND_MRSP || errKind == KIND_PW;
wire enOk = errType < 3'h3 && errEnableFf[errType[1:0]];
wire fmtOk = !(errKind == KIND_MREQ && errWellFormed);
wire captureHit = errValid && kindOk && errHopCount == 8'h00 && enOk && fmtOk;
wire clearCapture = regWrStb && isCapture && regWrData == `LTEC_RESET_VALUE;
wire [NPORTS-1:0] expireNow;

////////////////////////////////////////////////////////////////////////////////
// Capture register and lock
always @(posedge clk) begin
    if (srst) begin
        captureFf <= 8'h00;
        lockFf <= 1'b0;
    end else if (captureHit && !lockFf) begin
        captureFf <= {errFtype, errTtype};
        lockFf <= 1'b1;
    end else if (clearCapture) begin
        captureFf <= 8'h00;
        lockFf <= 1'b0;
    end else if (regWrStb && isCapture && !lockFf) begin
        captureFf <= regWrData[31:24];
    end
end

////////////////////////////////////////////////////////////////////////////////
// Broadcast configuration registers and enables
always @(posedge clk) begin
    if (srst) begin
        for (i = 0; i < NPORTS; i = i + 1) begin
            pwTargetFf[i] <= 17'h00000;
            lifetimeFf[i] <= 16'h0000;
        end
        errEnableFf <= 3'h0;
        intMaskFf <= 2'h0;
    end else if (regWrStb) begin
        for (i = 0; i < NPORTS; i = i + 1) begin
            if (isPwTarget) begin
                pwTargetFf[i] <= {regWrData[31:16], regWrData[`LTEC_WIDE_BIT]};
            end
            if (isLifetime) begin
                lifetimeFf[i] <= regWrData[`LTEC_TTL_HI:`LTEC_TTL_LO];
            end
        end
        if (regAddr == `LTEC_OFS_ERRENABLE) begin
            errEnableFf <= regWrData[2:0];
        end
        if (regAddr == `LTEC_OFS_INTMASK) begin
            intMaskFf <= regWrData[1:0];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupt status: set wins over write-one-to-clear
always @(posedge clk) begin
    if (srst) begin
        intStatFf <= 2'h0;
        irq <= 1'b0;
    end else begin
        intStatFf[`LTEC_INT_CAPTURE] <= (captureHit && !lockFf) ||
            (intStatFf[`LTEC_INT_CAPTURE] &&
             !(regWrStb && regAddr == `LTEC_OFS_INTSTAT && regWrData[`LTEC_INT_CAPTURE]));
        intStatFf[`LTEC_INT_DROP] <= (|expireNow) ||
            (intStatFf[`LTEC_INT_DROP] &&
             !(regWrStb && regAddr == `LTEC_OFS_INTSTAT && regWrData[`LTEC_INT_DROP]));
        irq <= |(intStatFf & intMaskFf);
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read port, data one cycle after the strobe
always @(posedge clk) begin
    if (srst) begin
        regRdData <= 32'h00000000;
    end else if (regRdStb) begin
        if (isCapture) begin
            regRdData <= {captureFf, 24'h000000};
        end else if (isPwTarget) begin
            regRdData <= pwWord(pwTargetFf[0]);
        end else if (isLifetime) begin
            regRdData <= {lifetimeFf[0], 16'h0000};
        end else if (regAddr == `LTEC_OFS_ERRENABLE) begin
            regRdData <= {29'h00000000, errEnableFf};
        end else if (regAddr == `LTEC_OFS_INTSTAT) begin
            regRdData <= {30'h00000000, intStatFf};
        end else if (regAddr == `LTEC_OFS_INTMASK) begin
            regRdData <= {30'h00000000, intMaskFf};
        end else begin
            regRdData <= 32'h00000000;
        end
    end else begin
        regRdData <= 32'h00000000;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Ageing: coarse tick of 16 clocks, expiry after four ticks per lifetime unit plus the partial first tick
reg [15:0] preFf;
wire tick = preFf == TICK_CYC[15:0] - 16'h0001;
always @(posedge clk) begin
    if (srst || tick) begin
        preFf <= 16'h0000;
    end else begin
        preFf <= preFf + 16'h0001;
    end
end

genvar g;
generate
    for (g = 0; g < NPORTS; g = g + 1) begin : gAge
        reg activeFf;
        reg [17:0] ageFf;
        // A shared tick adds up to one tick of jitter, so the tick must stay well below the window width
        assign expireNow[g] = activeFf && !pktDone[g] && lifetimeFf[g] != 16'h0000 &&
            tick && ageFf >= {lifetimeFf[g], 2'b00};
        always @(posedge clk) begin
            if (srst) begin
                activeFf <= 1'b0;
                ageFf <= 18'h00000;
            end else if (pktStart[g]) begin
                activeFf <= 1'b1;
                ageFf <= 18'h00000;
            end else if (pktDone[g] || expireNow[g]) begin
                activeFf <= 1'b0;
            end else if (activeFf && tick && ageFf != 18'h3FFFF) begin
                ageFf <= ageFf + 18'h00001;
            end
        end
    end
endgenerate

always @(posedge clk) begin
    if (srst) begin
        dropFf <= {NPORTS{1'b0}};
        pktExpire <= {NPORTS{1'b0}};
        outputDrop <= {NPORTS{1'b0}};
    end else begin
        pktExpire <= expireNow;
        dropFf <= dropFf | expireNow;
        outputDrop <= dropFf | expireNow;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Port-write destination generation
always @(posedge clk) begin
    if (srst) begin
        pwValid <= 1'b0;
        pwDestId <= {ID_W{1'b0}};
        pwWide <= 1'b0;
        pwOutPort <= 4'h0;
    end else begin
        pwValid <= pwReq;
        if (pwReq) begin
            pwWide <= pwTargetFf[0][0];
            pwOutPort <= pwLutPort;
            if (pwTargetFf[0][0]) begin
                pwDestId <= pwTargetFf[0][16:1];
            end else begin
                pwDestId <= {8'h00, pwTargetFf[0][8:1]};
            end
        end
    end
end

endmodule

// ### dv/ltec_monitor.sv
// Checker of the port-write and ageing outputs
module ltec_monitor #(
    parameter NPORTS = 4,
    parameter ID_W = 16
) (
    // Clock and reset
    input wire clk,
    input wire srst,
    // Port-write
    input wire pwReq,
    input wire [3:0] pwLutPort,
    input wire pwValid,
    input wire [ID_W-1:0] pwDestId,
    input wire pwWide,
    input wire [3:0] pwOutPort,
    // Ageing and interrupt
    input wire [NPORTS-1:0] pktExpire,
    input wire [NPORTS-1:0] outputDrop,
    input wire irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    ////////////////////////////////////////
    a_pw_latency: assert property (pwReq |=> pwValid)
        else $error("pw late");
    a_pw_spurious: assert property (!pwReq |=> !pwValid)
        else $error("pw spurious");
    a_pw_route: assert property (pwReq |=> pwOutPort == $past(pwLutPort))
        else $error("pw port");
    a_pw_narrow: assert property (pwValid && !pwWide |-> pwDestId[ID_W-1:8] == 0)
        else $error("pw high byte");
    a_pw_hold: assert property (!pwReq |=> $stable({pwDestId, pwWide, pwOutPort}))
        else $error("pw moved");
    a_drop_sticky: assert property (1 |=> ($past(outputDrop) & ~outputDrop) == 0)
        else $error("drop cleared");
    a_expire_drop: assert property (|pktExpire |=> (outputDrop & $past(pktExpire)) == $past(pktExpire))
        else $error("drop unset");
    a_expire_pulse: assert property (|pktExpire |=> (pktExpire & $past(pktExpire)) == 0)
        else $error("expire long");
    ////////////////////////////////////////
    c_pw_wide: cover property (pwValid && pwWide);
    c_expire: cover property (|pktExpire);
    c_irq: cover property (irq);
endmodule
bind lteccfg_top ltec_monitor #(.NPORTS(NPORTS), .ID_W(ID_W)) i_mon (.clk, .srst, .pwReq, .pwLutPort,
    .pwValid, .pwDestId, .pwWide, .pwOutPort, .pktExpire, .outputDrop, .irq);

// ### dv/ltec_fabric.sv
// Fabric model: error reports, packet entry and exit, port-write requests
module ltec_fabric (
    // Clock
    input wire clk,
    // Error report
    output logic errValid,
    output wire [2:0] errType,
    output wire [1:0] errKind,
    output wire [7:0] errHopCount,
    output wire errWellFormed,
    output wire [3:0] errFtype,
    output wire [3:0] errTtype,
    // Ageing and port-write
    output logic [3:0] pktStart,
    output logic [3:0] pktDone,
    output logic pwReq,
    output logic [3:0] pwLutPort
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [21:0] ef = 0;
    assign {errType, errKind, errHopCount, errWellFormed, errFtype, errTtype} = ef;
    initial {errValid, pktStart, pktDone, pwReq, pwLutPort} = 0;
    ////////////////////////////////////////
    // Released error and port-write fields show the inverse, never the last value; packet strobes return to zero
    task automatic err(input [21:0] f);
        @(posedge clk);
        {errValid, ef} <= {1'b1, f};
        @(posedge clk);
        {errValid, ef} <= {1'b0, ~f};
    endtask
    task automatic pkt(input [3:0] s, input [3:0] d);
        @(posedge clk);
        {pktStart, pktDone} <= {s, d};
        @(posedge clk);
        {pktStart, pktDone} <= 8'h00;
    endtask
    task automatic pw(input [3:0] p);
        @(posedge clk);
        {pwReq, pwLutPort} <= {1'b1, p};
        @(posedge clk);
        {pwReq, pwLutPort} <= {1'b0, ~p};
    endtask
endmodule

// ### dv/tb.sv
// Testbench of the capture, port-write target and lifetime registers
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, srst = 1, regWrStb = 0, regRdStb = 0;
    logic [15:0] regAddr = 0;
    logic [31:0] regWrData = 0;
    wire [31:0] regRdData;
    wire errValid, errWellFormed, pwReq, pwValid, pwWide, irq;
    wire [2:0] errType;
    wire [1:0] errKind;
    wire [7:0] errHopCount;
    wire [3:0] errFtype, errTtype, pwLutPort, pwOutPort, pktStart, pktDone, pktExpire, outputDrop;
    wire [15:0] pwDestId;
    int fails = 0, tests_run = 0, cyc = 0, n;
    lteccfg_top i_dut (.clk, .srst, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData, .errValid,
        .errType, .errKind, .errHopCount, .errWellFormed, .errFtype, .errTtype, .pktStart, .pktDone, .pwReq,
        .pwLutPort, .pktExpire, .outputDrop, .pwValid, .pwDestId, .pwWide, .pwOutPort, .irq);
    ltec_fabric i_fab (.clk, .errValid, .errType, .errKind, .errHopCount, .errWellFormed, .errFtype,
        .errTtype, .pktStart, .pktDone, .pwReq, .pwLutPort);
    always #10 clk = ~clk;
    ////////////////////////////////////////
    task automatic chk(input string nm, input [31:0] seen, input [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input [15:0] a, input [31:0] d);
        @(posedge clk);
        {regWrStb, regAddr, regWrData} <= {1'b1, a, d};
        @(posedge clk);
        regWrStb <= 0;
    endtask
    task automatic rd(input [15:0] a, input [31:0] e, input string nm);
        @(posedge clk);
        {regRdStb, regAddr} <= {1'b1, a};
        @(posedge clk);
        regRdStb <= 0;
        #1 chk(nm, regRdData, e);
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // Error report: type, kind, hop count, well formed, format and transaction type
    task automatic er(input [2:0] t, input [1:0] k, input [7:0] h, input w, input [7:0] ft);
        i_fab.err({t, k, h, w, ft});
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            test_done;
        end
    end
    ////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk);
        srst <= 0;
        rd(16'h101C, 0, "capture");
        rd(16'h1028, 0, "target");
        rd(16'h102C, 0, "lifetime");
        rd(16'h1FF0, 0, "unmapped");
        $display("test reset done");
        er(0, 0, 0, 0, 8'h85);
        rd(16'h101C, 0, "cap disabled");
        wr(16'h1030, 32'h7);
        er(0, 0, 0, 0, 8'h85);
        rd(16'h101C, 32'h85000000, "cap");
        er(1, 0, 0, 0, 8'h3A);
        wr(16'h101C, 32'h12345678);
        rd(16'h101C, 32'h85000000, "cap locked");
        wr(16'h101C, 0);
        wr(16'h1030, 32'h2);
        er(0, 0, 0, 0, 8'h85);
        er(1, 0, 1, 0, 8'h85);
        er(1, 3, 0, 0, 8'h85);
        er(1, 0, 0, 1, 8'h85);
        rd(16'h101C, 0, "cap filtered");
        er(1, 2, 0, 0, 8'hC4);
        rd(16'h101C, 32'hC4000000, "cap pw");
        $display("test capture done");
        rd(16'h1034, 32'h1, "status");
        chk("irq masked", irq, 0);
        wr(16'h1038, 32'h3);
        tick(2);
        chk("irq", irq, 1);
        wr(16'h1034, 32'h1);
        tick(2);
        chk("irq clear", irq, 0);
        $display("test interrupt done");
        wr(16'h1028, 32'hA53C7FFF);
        rd(16'h1028, 32'hA53C0000, "target");
        i_fab.pw(4'h6);
        #1 chk("pw narrow", {pwValid, pwWide, pwOutPort, pwDestId}, {6'h26, 16'h003C});
        wr(16'h1028, 32'hA53C8000);
        i_fab.pw(4'h9);
        #1 chk("pw wide", {pwValid, pwWide, pwOutPort, pwDestId}, {6'h39, 16'hA53C});
        $display("test port-write done");
        wr(16'h102C, 32'h0000FFFF);
        rd(16'h102C, 0, "lifetime");
        i_fab.pkt(4'h4, 0);
        tick(200);
        chk("drop off", outputDrop, 0);
        i_fab.pkt(0, 4'h4);
        wr(16'h102C, 32'h0001FFFF);
        rd(16'h102C, 32'h00010000, "lifetime");
        i_fab.pkt(4'h2, 0);
        i_fab.pkt(0, 4'h2);
        tick(120);
        chk("drop exit", outputDrop, 0);
        i_fab.pkt(4'hF, 0);
        n = 0;
        #1;
        while (pktExpire === 4'h0 && n < 300) begin
            @(posedge clk);
            #1 n++;
        end
        chk("expire ports", pktExpire, 4'hF);
        chk("expire time", (n + 2) * 20 >= 78 * 16 && n * 20 <= 117 * 16, 1);
        tick(1);
        chk("drop", outputDrop, 4'hF);
        rd(16'h1034, 32'h2, "drop status");
        chk("irq drop", irq, 1);
        $display("test lifetime done");
        test_done;
    end
endmodule
